// ===== design/cfg_port_dev.sv
// Device end: configuration serial port and its register file
// What this block does
// - Host keeps serial clock at most 80 MHz
// - Sample incoming bits on serial clock rise
// - Launch read bits on serial clock fall
// - Release shared data pin while select high
// - Host holds select low whole cycle
// - Mirrored bits 6/1 choose LSB first
// - MSB order: flag, address, data downward
// - LSB order: address, flag, data upward
// - Mirrored bits 4/3 enable separate output
// - First byte hits instruction's address
// - Each further byte steps the address
// - Bits 5/2 choose step up or down
// - Select high then low aborts transfer
// - Config register writes use first nibble
// - Sixteen instruction bits: flag and address
// - Register updates on each byte's last bit
`timescale 1ns/1ps
module cfg_port_dev (
    input  wire logic  pclk,
    input  wire logic  presetn,
    spi_link_if.dev    link,
    output logic [7:0] cfg_value,
    output logic       wr_stb,
    output logic [14:0] wr_addr,
    output logic [7:0] wr_data,
    output logic       soft_reset
);
    typedef enum logic {
        PH_INSTR,
        PH_DATA
    } phase_e;

    typedef struct packed {
        logic [15:0][7:0] regs;
        phase_e           phase;
        logic [3:0]       cnt;
        logic [15:0]      sr;
        logic             rw;
        logic [14:0]      addr;
        logic             dout;
        logic             oe;
        logic             wr_stb;
        logic [14:0]      wr_addr;
        logic [7:0]       wr_data;
        logic             srst;
    } dev_s;

    dev_s r;
    dev_s n;

    logic cs_hi;
    logic sclk_rise;
    logic sclk_fall;
    logic din;
    logic lsb_first;
    logic step_up;
    logic four_wire;

    edge_sync #(.INIT(1'b1)) u_cs (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (link.cs_n),
        .lvl     (cs_hi),
        .rise    (),
        .fall    ()
    );

    edge_sync #(.INIT(1'b0)) u_sclk (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (link.sclk),
        .lvl     (),
        .rise    (sclk_rise),
        .fall    (sclk_fall)
    );

    edge_sync #(.INIT(1'b1)) u_sdio (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (link.sdio),
        .lvl     (din),
        .rise    (),
        .fall    ()
    );

    // Mode bits from the mirrored pairs
    // bit order select
    assign lsb_first = r.regs[0][spi_cfg_pkg::LSB_BIT_A]
                     | r.regs[0][spi_cfg_pkg::LSB_BIT_B];
    assign step_up   = r.regs[0][spi_cfg_pkg::STEP_BIT_A]
                     | r.regs[0][spi_cfg_pkg::STEP_BIT_B];
    assign four_wire = r.regs[0][spi_cfg_pkg::SDO_BIT_A]
                     | r.regs[0][spi_cfg_pkg::SDO_BIT_B];

    // Byte currently addressed, zero outside the register space
    function automatic logic [7:0] rd_byte(input dev_s s);
        rd_byte = 8'h00;
        if (s.addr < spi_cfg_pkg::REG_COUNT) begin
            rd_byte = s.regs[s.addr[3:0]];
        end
    endfunction

    // Mirror the first received nibble into a full config byte
    function automatic logic [7:0] cfg_from_nibble(input logic [7:0] d,
                                                   input logic lsb);
        logic [3:0] nib;
        nib = lsb ? {d[0], d[1], d[2], d[3]} : d[7:4];
        cfg_from_nibble = {nib, nib[0], nib[1], nib[2], nib[3]};
    endfunction

    // Serial protocol engine
    always_comb begin
        logic [7:0] cfg_new;
        logic [2:0] pos;
        logic [7:0] rb;
        rb       = rd_byte(r);
        cfg_new  = 8'h00;
        pos      = 3'h0;
        n        = r;
        n.wr_stb = 1'b0;
        n.srst   = 1'b0;
        if (cs_hi) begin
            n.phase = PH_INSTR;
            n.cnt   = 4'h0;
            n.oe    = 1'b0;
        end else begin
            if (sclk_rise) begin
                if (r.phase == PH_INSTR) begin
                    n.sr  = lsb_first ? {din, r.sr[15:1]}
                                      : {r.sr[14:0], din};
                    n.cnt = r.cnt + 4'h1;
                    if (r.cnt == 4'(spi_cfg_pkg::INSTR_BITS - 6'h1)) begin
                        n.phase = PH_DATA;
                        n.cnt   = 4'h0;
                        n.rw    = n.sr[15];
                        n.addr  = n.sr[14:0];
                    end
                end else begin
                    n.sr[7:0] = lsb_first ? {din, r.sr[7:1]}
                                          : {r.sr[6:0], din};
                    n.cnt     = {1'b0, r.cnt[2:0] + 3'h1};
                    if (r.cnt[2:0] ==
                        3'(spi_cfg_pkg::BYTE_BITS - 6'h1)) begin
                        // commit on the byte's last bit
                        if (!r.rw && r.addr < spi_cfg_pkg::REG_COUNT) begin
                            n.wr_stb  = 1'b1;
                            n.wr_addr = r.addr;
                            n.wr_data = n.sr[7:0];
                            if (r.addr == spi_cfg_pkg::CFG_ADDR) begin
                                cfg_new = cfg_from_nibble(n.sr[7:0],
                                                          lsb_first);
                                n.wr_data = cfg_new;
                                if (cfg_new[spi_cfg_pkg::SRST_BIT_A] |
                                    cfg_new[spi_cfg_pkg::SRST_BIT_B]) begin
                                    n.srst = 1'b1;
                                    n.regs = {16{spi_cfg_pkg::OTHER_RESET}};
                                    n.regs[0] = spi_cfg_pkg::CFG_RESET;
                                end else begin
                                    n.regs[0] = cfg_new;
                                end
                            end else begin
                                n.regs[r.addr[3:0]] = n.sr[7:0];
                            end
                        end
                        n.addr = step_up ? r.addr + 15'h1
                                         : r.addr - 15'h1;
                    end
                end
            end
            if (sclk_fall && r.phase == PH_DATA && r.rw) begin
                // next read bit on the fall
                pos    = lsb_first ? r.cnt[2:0] : 3'h7 - r.cnt[2:0];
                n.oe   = 1'b1;
                n.dout = rb[pos];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r         <= '0;
            r.regs    <= {16{spi_cfg_pkg::OTHER_RESET}};
            r.regs[0] <= spi_cfg_pkg::CFG_RESET;
            r.phase   <= PH_INSTR;
        end else begin
            r <= n;
        end
    end

    // Pin drive
    // shared pin only for read data
    assign link.sdio_d_oe_n = ~(r.oe & ~four_wire & ~cs_hi);
    assign link.sdio_d      = r.dout;
    // separate output only in four-wire mode
    assign link.separate_output_pin         = r.oe & four_wire & r.dout;

    assign cfg_value  = r.regs[0];
    assign wr_stb     = r.wr_stb;
    assign wr_addr    = r.wr_addr;
    assign wr_data    = r.wr_data;
    assign soft_reset = r.srst;
endmodule

// ===== design/cfg_port_host.sv
// Controller end: APB-driven master of the configuration serial port
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module cfg_port_host (
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic   psel,
    input  wire logic   penable,
    input  wire logic   pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    spi_link_if.host    link
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_SHIFT,
        ST_END,
        ST_GAP
    } state_e;

    typedef struct packed {
        state_e      state;
        logic [19:0] cmd;
        logic [31:0] txd;
        logic [31:0] rxd;
        logic [31:0] prdata;
        logic [3:0]  dv;
        logic [5:0]  bits;
        logic [47:0] stream;
        logic [31:0] rx;
        logic        sclk;
        logic        cs_n;
        logic        sdo_o;
        logic        oe;
    } host_s;

    host_s r;
    host_s n;

    logic sdio_s;
    logic sdo_s;

    edge_sync #(.INIT(1'b1)) u_sdio (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (link.sdio),
        .lvl     (sdio_s),
        .rise    (),
        .fall    ()
    );

    edge_sync #(.INIT(1'b0)) u_sdo (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (link.separate_output_pin),
        .lvl     (sdo_s),
        .rise    (),
        .fall    ()
    );

    // Sequencer and APB register file
    always_comb begin
        logic       rd;
        logic       lsb;
        logic [1:0] cnt;
        logic [5:0] total;
        logic [15:0] ins;
        logic [7:0] b;
        logic [31:0] tmp;
        n   = r;
        rd  = r.cmd[spi_cfg_pkg::CMD_RW_BIT];
        lsb = r.cmd[spi_cfg_pkg::CMD_LSB_BIT];
        cnt = r.cmd[spi_cfg_pkg::CMD_CNT_LSB +: 2];
        total = spi_cfg_pkg::INSTR_BITS
              + spi_cfg_pkg::BYTE_BITS * (6'(cnt) + 6'h1);
        ins = 16'h0;
        b   = 8'h0;
        tmp = 32'h0;
        // APB read data captured in the setup cycle
        if (psel && !penable) begin
            unique case (paddr)
                spi_cfg_pkg::CMD_OFF:  n.prdata = {12'h0, r.cmd};
                spi_cfg_pkg::TXD_OFF:  n.prdata = r.txd;
                spi_cfg_pkg::RXD_OFF:  n.prdata = r.rxd;
                spi_cfg_pkg::STAT_OFF: n.prdata = {31'h0,
                                                   r.state != ST_IDLE};
                default:               n.prdata = 32'h0;
            endcase
        end
        // APB writes, taken only while idle
        if (psel && penable && pwrite && r.state == ST_IDLE) begin
            if (paddr == spi_cfg_pkg::TXD_OFF) begin
                n.txd = pwdata;
            end
            if (paddr == spi_cfg_pkg::CMD_OFF) begin
                n.cmd = pwdata[19:0];
                ins   = pwdata[15:0];
                if (pwdata[spi_cfg_pkg::CMD_LSB_BIT]) begin
                    ins = {<<{ins}};
                end
                n.stream[47:32] = ins;
                for (int k = 0; k < 4; k++) begin
                    b = r.txd[8*k +: 8];
                    if (pwdata[spi_cfg_pkg::CMD_LSB_BIT]) begin
                        b = {<<{b}};
                    end
                    n.stream[31 - 8*k -: 8] = b;
                end
                n.state = ST_SETUP;
                n.cs_n  = 1'b0;
                n.sdo_o = ins[15];
                n.oe    = 1'b1;
                n.dv    = 4'h0;
                n.bits  = 6'h0;
                n.rx    = 32'h0;
            end
        end
        unique case (r.state)
            ST_IDLE: begin
                n.sclk = 1'b0;
            end
            ST_SETUP, ST_END, ST_GAP: begin
                n.dv = r.dv + 4'h1;
                if (r.dv == spi_cfg_pkg::SCLK_HALF_CYC - 4'h1) begin
                    n.dv = 4'h0;
                    if (r.state == ST_SETUP) begin
                        n.state = ST_SHIFT;
                    end else if (r.state == ST_END) begin
                        n.state = ST_GAP;
                        n.cs_n  = 1'b1;
                        n.oe    = 1'b0;
                        for (int k = 0; k < 4; k++) begin
                            tmp = r.rx >> (8 * (32'(cnt) - k));
                            b   = tmp[7:0];
                            if (lsb) begin
                                b = {<<{b}};
                            end
                            n.rxd[8*k +: 8] = (k <= 32'(cnt)) ? b : 8'h0;
                        end
                    end else begin
                        n.state = ST_IDLE;
                    end
                end
            end
            ST_SHIFT: begin
                n.dv = r.dv + 4'h1;
                if (r.dv == spi_cfg_pkg::SCLK_HALF_CYC - 4'h1) begin
                    n.dv   = 4'h0;
                    n.sclk = ~r.sclk;
                    if (!r.sclk) begin
                        n.bits = r.bits + 6'h1;
                        if (r.bits >= spi_cfg_pkg::INSTR_BITS) begin
                            n.rx = {r.rx[30:0],
                                    r.cmd[spi_cfg_pkg::CMD_4W_BIT]
                                        ? sdo_s : sdio_s};
                        end
                    end else if (r.bits == total) begin
                        n.state = ST_END;
                        n.oe    = ~rd;
                    end else begin
                        n.stream = {r.stream[46:0], 1'b0};
                        n.sdo_o  = r.stream[46];
                        n.oe     = ~(rd && r.bits >=
                                     spi_cfg_pkg::INSTR_BITS);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r       <= '0;
            r.state <= ST_IDLE;
            r.cs_n  <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign prdata           = r.prdata;
    assign pready           = 1'b1;
    assign pslverr          = 1'b0;
    assign link.cs_n        = r.cs_n;
    assign link.sclk        = r.sclk;
    assign link.sdio_h      = r.sdo_o;
    assign link.sdio_h_oe_n = ~r.oe;
endmodule

// ===== design/edge_sync.sv
// Two-stage synchroniser with edge detection behind it
`timescale 1ns/1ps
module edge_sync #(
    parameter logic INIT = 1'b0
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic din,
    output logic      lvl,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sync_s;

    sync_s r;
    sync_s n;

    // Shift chain, first stage feeds only the second
    always_comb begin
        n    = r;
        n.s1 = din;
        n.s2 = r.s1;
        n.s3 = r.s2;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{INIT, INIT, INIT};
        end else begin
            r <= n;
        end
    end

    assign lvl  = r.s2;
    assign rise = r.s2 & ~r.s3;
    assign fall = ~r.s2 & r.s3;
endmodule

// ===== design/spi_cfg_pkg.sv
// Shared constants for the configuration serial port and its controller
package spi_cfg_pkg;
    // Device register space
    localparam logic [14:0] CFG_ADDR    = 15'h0000;
    localparam logic [14:0] REG_COUNT   = 15'h0010;
    localparam logic [7:0]  CFG_RESET   = 8'h00;
    localparam logic [7:0]  OTHER_RESET = 8'h00;
    // Mirrored bit pairs of serial_interface_config
    localparam int LSB_BIT_A  = 6;
    localparam int LSB_BIT_B  = 1;
    localparam int STEP_BIT_A = 5;
    localparam int STEP_BIT_B = 2;
    localparam int SDO_BIT_A  = 4;
    localparam int SDO_BIT_B  = 3;
    localparam int SRST_BIT_A = 7;
    localparam int SRST_BIT_B = 0;
    // Frame layout
    localparam logic [5:0] INSTR_BITS = 6'h10;
    localparam logic [5:0] BYTE_BITS  = 6'h08;
    // Timing: link clock limit and controller half period
    localparam int PCLK_MHZ      = 200;
    localparam int SCLK_MAX_MHZ  = 80;
    localparam int SCLK_MIN_HALF =
        (PCLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
    localparam logic [3:0] SCLK_HALF_CYC = 4'(4 * SCLK_MIN_HALF);
    // Controller APB map
    localparam logic [7:0] CMD_OFF  = 8'h00;
    localparam logic [7:0] TXD_OFF  = 8'h04;
    localparam logic [7:0] RXD_OFF  = 8'h08;
    localparam logic [7:0] STAT_OFF = 8'h0c;
    // CMD and STAT fields
    localparam int CMD_RW_BIT  = 15;
    localparam int CMD_LSB_BIT = 16;
    localparam int CMD_CNT_LSB = 17;
    localparam int CMD_4W_BIT  = 19;
    localparam int STAT_BUSY_BIT = 0;
endpackage

// ===== design/spi_link_if.sv
// Serial configuration link between controller and device
`timescale 1ns/1ps
interface spi_link_if;
    logic cs_n;
    logic sclk;
    logic sdio_h;
    logic sdio_h_oe_n;
    logic sdio_d;
    logic sdio_d_oe_n;
    logic sdio;
    logic separate_output_pin;

    // Shared data wire, pulled high when nobody drives
    assign sdio = !sdio_d_oe_n ? sdio_d :
                  !sdio_h_oe_n ? sdio_h : 1'b1;

    modport dev (
        input  cs_n,
        input  sclk,
        input  sdio,
        output sdio_d,
        output sdio_d_oe_n,
        output separate_output_pin
    );
    modport host (
        output cs_n,
        output sclk,
        output sdio_h,
        output sdio_h_oe_n,
        input  sdio,
        input  separate_output_pin
    );
endinterface

// ===== sim/config_serial_port_chk.sv
// Link-level checker for the configuration serial port
`timescale 1ns/1ps
module config_serial_port_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdio_h,
    input wire logic sdio_h_oe_n,
    input wire logic sdio_d,
    input wire logic sdio_d_oe_n,
    input wire logic sdio,
    input wire logic separate_output_pin
);
    logic [7:0] rise_cnt;
    logic       sclk_q;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Counts serial clock rises within a frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_cnt <= 8'h00;
            sclk_q   <= 1'b0;
        end else begin
            sclk_q <= sclk;
            if (cs_n) begin
                rise_cnt <= 8'h00;
            end else if (sclk && !sclk_q) begin
                rise_cnt <= rise_cnt + 8'h01;
            end
        end
    end

    property p_sclk_hi;
        $rose(sclk) |-> sclk [*3];
    endproperty
    a_sclk_hi: assert property (p_sclk_hi)
        else $error("serial clock high phase too short");
    property p_sclk_lo;
        $fell(sclk) |-> !sclk [*3];
    endproperty
    a_sclk_lo: assert property (p_sclk_lo)
        else $error("serial clock low phase too short");
    property p_host_bit;
        !sdio_h_oe_n && $changed(sdio_h) |-> !sclk;
    endproperty
    a_host_bit: assert property (p_host_bit)
        else $error("host data moved while clock high");
    property p_dev_bit;
        !sdio_d_oe_n && $changed(sdio_d) |-> !sclk;
    endproperty
    a_dev_bit: assert property (p_dev_bit)
        else $error("device data moved while clock high");
    property p_release;
        cs_n [*6] |-> sdio_d_oe_n;
    endproperty
    a_release: assert property (p_release)
        else $error("device drives data pin while deselected");
    property p_sel_low;
        $rose(sclk) |-> !cs_n;
    endproperty
    a_sel_low: assert property (p_sel_low)
        else $error("clock edge outside a selected frame");
    property p_sdo_excl;
        !sdio_d_oe_n |-> !separate_output_pin;
    endproperty
    a_sdo_excl: assert property (p_sdo_excl)
        else $error("separate output active in three-wire read");
    property p_whole_bytes;
        $rose(cs_n) |-> rise_cnt >= 8'h18 && rise_cnt[2:0] == 3'h0;
    endproperty
    a_whole_bytes: assert property (p_whole_bytes)
        else $error("frame is not instruction plus whole bytes");
    property p_instr_phase;
        !sdio_d_oe_n && !cs_n |-> rise_cnt >= 8'h10;
    endproperty
    a_instr_phase: assert property (p_instr_phase)
        else $error("device drove pin during instruction");
    property p_no_clash;
        !sdio_h_oe_n |-> sdio_d_oe_n;
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("both ends drive the shared pin");
endmodule

// ===== sim/tb_config_serial_port.sv
// Testbench joining controller and device over the serial link
`timescale 1ns/1ps
module tb_config_serial_port;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  cfg_value;
    logic        wr_stb;
    logic [14:0] wr_addr;
    logic [7:0]  wr_data;
    logic        soft_reset;
    logic [7:0]  mem [16];
    logic [3:0]  nib [4] = '{4'h0, 4'h2, 4'h3, 4'h6};
    logic [31:0] q;
    logic [31:0] d;
    logic [14:0] a;
    logic [7:0]  v;
    logic [7:0]  e;
    logic        up;
    int          n;
    int          k;
    int          fails;
    int          comparisons;
    int          cyc;
    int          wr_cnt;
    int          srst_cnt;

    spi_link_if link ();
    cfg_port_host i_cfg_port_host (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    cfg_port_dev i_cfg_port_dev (.pclk(pclk), .presetn(presetn),
        .link(link), .cfg_value(cfg_value), .wr_stb(wr_stb),
        .wr_addr(wr_addr), .wr_data(wr_data), .soft_reset(soft_reset));
    config_serial_port_chk i_config_serial_port_chk (.pclk(pclk),
        .presetn(presetn), .cs_n(link.cs_n), .sclk(link.sclk),
        .sdio_h(link.sdio_h), .sdio_h_oe_n(link.sdio_h_oe_n),
        .sdio_d(link.sdio_d), .sdio_d_oe_n(link.sdio_d_oe_n),
        .sdio(link.sdio), .separate_output_pin(link.separate_output_pin));

    always #2.5 pclk = ~pclk;

    // Pulse counters and hang guard
    always @(posedge pclk) begin
        cyc++;
        if (wr_stb === 1'b1) wr_cnt++;
        if (soft_reset === 1'b1) srst_cnt++;
        if (cyc == 60000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t byte %h expected %h", $time, got, exp);
        end
    endtask

    // Config byte applied from its first nibble in the given order
    function automatic logic [7:0] mirror(input logic [7:0] x,
                                          input logic       lsb);
        logic [3:0] h;
        h = lsb ? {x[0], x[1], x[2], x[3]} : x[7:4];
        return {h, h[0], h[1], h[2], h[3]};
    endfunction

    function automatic logic [14:0] step(input logic [14:0] x);
        return (mem[0][5] | mem[0][2]) ? x + 15'h1 : x - 15'h1;
    endfunction

    function automatic logic [31:0] expect_rd(input logic [14:0] x,
                                              input int m);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < m; i++) begin
            r[8*i +: 8] = (x < 15'h10) ? mem[x[3:0]] : 8'h00;
            x = step(x);
        end
        return r;
    endfunction

    // One APB access, idle cycle after
    task automatic apb(input logic wr, input logic [7:0] ad,
                       input logic [31:0] wd, output logic [31:0] rd);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Full frame through the controller, model updated on writes
    task automatic frame(input logic rw, input logic [14:0] ad, input int m,
                         input logic [31:0] tx, output logic [31:0] rx);
        logic [31:0] cmd;
        logic [7:0]  b;
        logic [7:0]  c;
        cmd = {12'h0, mem[0][4] | mem[0][3], 2'(m - 1),
               mem[0][6] | mem[0][1], rw, ad};
        apb(1'b1, spi_cfg_pkg::TXD_OFF, tx, rx);
        apb(1'b1, spi_cfg_pkg::CMD_OFF, cmd, rx);
        do apb(1'b0, spi_cfg_pkg::STAT_OFF, 32'h0, rx);
        while (rx[spi_cfg_pkg::STAT_BUSY_BIT] !== 1'b0);
        apb(1'b0, spi_cfg_pkg::RXD_OFF, 32'h0, rx);
        for (int i = 0; i < m && !rw; i++) begin
            b = tx[8*i +: 8];
            c = mirror(b, mem[0][6] | mem[0][1]);
            if (ad == 15'h0 && c[7]) begin
                for (int j = 0; j < 16; j++)
                    mem[j] = 8'h00;
            end else if (ad == 15'h0) begin
                mem[0] = c;
            end else if (ad < 15'h10) begin
                mem[ad[3:0]] = b;
            end
            ad = step(ad);
        end
    endtask

    // Main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        {fails, comparisons, cyc, wr_cnt, srst_cnt} = '0;
        foreach (mem[i]) mem[i] = 8'h00;
        void'($urandom(25862));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk_byte(cfg_value, spi_cfg_pkg::CFG_RESET);
        apb(1'b0, 8'h40, 32'h0, q);
        chk_word(q, 32'h0);
        // Each order, step and wiring mode with random bursts
        for (int m = 0; m < 4; m++) begin
            v = {nib[m], 4'($urandom)};
            e = mirror(v, mem[0][6] | mem[0][1]);
            frame(1'b0, 15'h0, 1, {24'h0, v}, q);
            chk_byte(cfg_value, e);
            chk_byte(wr_data, e);
            for (int i = 0; i < 3; i++) begin
                n = 1 + $urandom % 4;
                up = mem[0][5] | mem[0][2];
                a = 15'(up ? 1 + $urandom % (16 - n)
                           : n + $urandom % (16 - n));
                d = $urandom;
                frame(1'b0, a, n, d, q);
                k = up ? int'(a) + n - 1 : int'(a) - n + 1;
                chk_word({17'h0, wr_addr}, 32'(k));
                frame(1'b1, a, n, 32'h0, q);
                chk_word(q, expect_rd(a, n));
            end
        end
        // Second nibble ignored in least-significant-first order too
        frame(1'b0, 15'h0, 1, {24'h0, 4'($urandom), 4'h0}, q);
        chk_byte(cfg_value, 8'h00);
        chk_byte(wr_data, 8'h00);
        // Write beyond the register space is dropped
        k = wr_cnt;
        frame(1'b0, 15'h12, 1, 32'h5a, q);
        chk_word(32'(wr_cnt), 32'(k));
        frame(1'b1, 15'h12, 1, 32'h0, q);
        chk_word(q, 32'h0);
        // Soft reset clears the register file
        k = srst_cnt;
        frame(1'b0, 15'h0, 1, {24'h0, 4'h8, 4'($urandom)}, q);
        chk_word(32'(srst_cnt), 32'(k + 1));
        chk_byte(cfg_value, 8'h00);
        frame(1'b1, 15'h4, 4, 32'h0, q);
        chk_word(q, expect_rd(15'h4, 4));
        print_verdict();
    end
endmodule
